// *** hw/usbh_cfg.svh ***
// Purpose: Register indices, field positions, resets and timing counts
// Assumes: 125 MHz clock, byte address equals index times four
// Notes:   Definitions only
`ifndef USBH_CFG_SVH
`define USBH_CFG_SVH
// ==================================================================
// Register indices
`define IDX_PORT_CTRL 7'h01
`define IDX_EP_MODE   7'h0d
`define IDX_RX_ADDR   7'h18
`define IDX_TX_ADDR   7'h1c
`define IDX_AUX_SETUP 7'h36
`define IDX_TOKEN     7'h38
`define IDX_RX_CTRL   7'h3b
`define IDX_TX_LEN    7'h3c
`define IDX_TX_CTRL   7'h3e
`define IDX_STATUS    7'h40
`define IDX_RX_MAX    7'h41
// ==================================================================
// Field positions
`define B_PD_DIS  7
`define B_DP      5
`define B_DM      4
`define B_SLOW    2
`define B_BRST    1
`define B_PEN     0
`define B_TX_EN   6
`define B_TX_DUAL 4
`define B_RX_EN   3
`define B_RX_DUAL 0
`define B_PRE     10
`define B_SOF     2
`define B_AUTO    3
`define B_TOG     2
`define B_RES     0
`define B_DONE    0
`define B_TOG_OK  1
`define B_HS_LSB  4
`define B_RXN_LSB 16
// ==================================================================
// Reset values and sizes
`define RST_PD_DIS 1'b1
`define BUF_SIZE   15'h040
// ==================================================================
// Timing
`define CLK_PERIOD_NS 8
`define FRAME_US      1000
`define DISC_NS       2500
`define FRAME_CYC (`FRAME_US * 1000 / `CLK_PERIOD_NS)
`define DISC_CYC ((`DISC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// *** hw/usbh_pkg.sv ***
// Purpose: Types shared by the host port control modules
// Assumes: Nothing
// Notes:   State of each module is one packed struct
package usbh_pkg;
  typedef enum logic [3:0] {
    PID_OUT   = 4'h1,
    PID_ACK   = 4'h2,
    PID_IN    = 4'h9,
    PID_SETUP = 4'hd
  } pid_t;

  typedef enum logic [1:0] {
    X_IDLE = 2'b01,
    X_WAIT = 2'b10
  } xact_st_t;

  typedef struct packed {
    xact_st_t    st;
    logic        is_in;
    logic        link_req;
    logic [3:0]  link_pid;
    logic [3:0]  link_endp;
    logic        link_data1;
    logic        link_expect_hs;
    logic [14:0] link_addr;
    logic [16:0] link_len;
    logic        done;
    logic        tx_flip;
    logic        rx_flip;
    logic        tog_ok;
    logic        no_hs;
    logic [3:0]  hs_pid;
    logic [10:0] rx_len;
  } xact_reg_t;

  typedef struct packed {
    logic        pd_dis;
    logic        low_speed;
    logic        bus_reset;
    logic        port_en;
    logic        tx_en;
    logic        tx_dual;
    logic        rx_en;
    logic        rx_dual;
    logic [15:0] rx_dma;
    logic [15:0] tx_dma;
    logic        pre_en;
    logic        sof_en;
    logic [7:0]  token;
    logic        rx_auto;
    logic        rx_tog;
    logic [16:0] tx_len;
    logic        tx_auto;
    logic        tx_tog;
    logic        tx_res;
    logic        done_flag;
    logic [10:0] rx_max;
    logic        dp_s1;
    logic        dp_s2;
    logic        dm_s1;
    logic        dm_s2;
    logic [8:0]  se0_cnt;
    logic [16:0] frame_cnt;
    logic        sof_req;
    logic        start;
    logic        waitrequest;
    logic [31:0] readdata;
    logic        pulldown_en;
    logic        line_oe;
  } ctrl_reg_t;
endpackage

// *** hw/usbh_xact.sv ***
// Purpose: Host transaction sequencer toward the serial engine
// Assumes: Start is a one-cycle pulse, link_done a one-cycle pulse
// Notes:   Token with a disabled endpoint is ignored
`timescale 1ns/1ps
`include "usbh_cfg.svh"
module usbh_xact
  import usbh_pkg::*;
(
  input  logic        clk,
  input  logic        srst,
  input  logic        start,
  input  logic [7:0]  token,
  input  logic        tx_en,
  input  logic        tx_dual,
  input  logic        tx_tog,
  input  logic        tx_res,
  input  logic [15:0] tx_dma,
  input  logic [16:0] tx_len,
  input  logic        rx_en,
  input  logic        rx_dual,
  input  logic        rx_tog,
  input  logic [15:0] rx_dma,
  input  logic [10:0] rx_max,
  input  logic        link_done,
  input  logic [3:0]  link_hs_pid,
  input  logic        link_rx_ok,
  input  logic        link_rx_data1,
  input  logic [10:0] link_rx_len,
  input  logic        link_rx_no_hs,
  output logic        busy,
  output xact_reg_t   q
);
  localparam xact_reg_t XACT_RST = '{st: X_IDLE, default: '0};
  xact_reg_t   s;
  xact_reg_t   n;
  logic        is_in;
  logic        is_out;
  logic [14:0] tx_base;
  logic [14:0] rx_base;

  // ================================================================
  // Buffer selection and sequencing
  always_comb begin
    n = s;
    n.done = 1'b0;
    n.tx_flip = 1'b0;
    n.rx_flip = 1'b0;
    is_in = token[7:4] == PID_IN;
    is_out = token[7:4] == PID_OUT || token[7:4] == PID_SETUP;
    tx_base = tx_dma[14:0] + ((tx_dual && tx_tog) ? `BUF_SIZE : 15'h0);
    rx_base = rx_dma[14:0] + ((rx_dual && rx_tog) ? `BUF_SIZE : 15'h0);
    case (s.st)
      X_IDLE: begin
        if (start && ((is_in && rx_en) || (is_out && tx_en))) begin
          n.st = X_WAIT;
          n.is_in = is_in;
          n.link_req = 1'b1;
          n.link_pid = token[7:4];
          n.link_endp = token[3:0];
          n.link_data1 = is_in ? rx_tog : tx_tog;
          n.link_expect_hs = is_in ? 1'b1 : !tx_res;
          n.link_addr = is_in ? rx_base : tx_base;
          n.link_len = is_in ? {6'h00, rx_max} : tx_len;
        end
      end
      X_WAIT: begin
        if (link_done) begin
          n.st = X_IDLE;
          n.link_req = 1'b0;
          n.done = 1'b1;
          n.hs_pid = link_hs_pid;
          if (s.is_in) begin
            n.rx_len = link_rx_len;
            n.tog_ok = link_rx_data1 == rx_tog;
            n.no_hs = link_rx_no_hs;
            n.rx_flip = link_rx_ok && link_rx_data1 == rx_tog;
          end else begin
            n.tx_flip = !s.link_expect_hs || link_hs_pid == PID_ACK;
          end
        end
      end
      default: n = XACT_RST;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s <= XACT_RST;
    end else begin
      s <= n;
    end
  end

  assign q = s;
  assign busy = s.st == X_WAIT;

  // ================================================================
  // Checks
  chk_tx_buf_pick: assert property (@(posedge clk) disable iff (srst)
    (s.st == X_IDLE && start && is_out && tx_en) |=>
      (s.link_addr == $past(tx_dma[14:0]) +
       ($past(tx_dual && tx_tog) ? 15'h040 : 15'h000)))
    else $error("transmit buffer address wrong");
  chk_rx_disabled: assert property (@(posedge clk) disable iff (srst)
    (s.st == X_IDLE && start && is_in && !rx_en) |=> s.st == X_IDLE)
    else $error("IN started with receive disabled");
  chk_data_pid: assert property (@(posedge clk) disable iff (srst)
    (s.st == X_IDLE && start && is_out && tx_en) |=>
      (s.link_data1 == $past(tx_tog) && s.link_req))
    else $error("data PID not from transmit toggle");
endmodule // usbh_xact

// *** hw/usbh_port_ctrl.sv ***
// Purpose: Host port control, endpoint setup and register slave
// Assumes: Avalon-MM byte addresses, index times four per register
// Notes:   Serial engine sits outside on the link ports
//
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`include "usbh_cfg.svh"
module usbh_port_ctrl
  import usbh_pkg::*;
#(
  parameter int unsigned FRAME_CYCLES = `FRAME_CYC
)(
  input  logic        clk,
  input  logic        srst,
  input  logic [8:0]  address,
  input  logic        read,
  input  logic        write,
  input  logic [3:0]  byteenable,
  input  logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic        waitrequest,
  input  logic        dp_in,
  input  logic        dm_in,
  output logic        dp_out,
  output logic        dm_out,
  output logic        dp_oe,
  output logic        dm_oe,
  output logic        pulldown_en,
  output logic        link_req,
  output logic [3:0]  link_pid,
  output logic [3:0]  link_endp,
  output logic        link_data1,
  output logic        link_expect_hs,
  output logic [14:0] link_addr,
  output logic [16:0] link_len,
  output logic        link_slow_rate,
  output logic        link_preamble,
  output logic        sof_req,
  input  logic        link_done,
  input  logic [3:0]  link_hs_pid,
  input  logic        link_rx_ok,
  input  logic        link_rx_data1,
  input  logic [10:0] link_rx_len,
  input  logic        link_rx_no_hs
);
  localparam logic [16:0] FRAME_LAST = 17'(FRAME_CYCLES - 1);
  localparam logic [8:0]  DISC_LAST = 9'(`DISC_CYC - 1);
  localparam ctrl_reg_t CTRL_RST = '{
    pd_dis: `RST_PD_DIS,
    waitrequest: 1'b1,
    default: '0
  };

  if (FRAME_CYCLES < 16 || FRAME_CYCLES > 131072) begin : g_bad_frame
    $error("FRAME_CYCLES outside 16..131072");
  end

  ctrl_reg_t   s;
  ctrl_reg_t   n;
  xact_reg_t   x;
  logic        busy;
  logic        acc;
  logic        se0;
  logic [6:0]  idx;
  logic [31:0] m;
  logic [31:0] rd;
  logic [31:0] mrg;

  // ================================================================
  // Register read image
  function automatic logic [31:0] reg_word(
    input logic [6:0] i,
    input ctrl_reg_t  c,
    input xact_reg_t  t
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    case (i)
      `IDX_PORT_CTRL: begin
        w[`B_PD_DIS] = c.pd_dis;
        w[`B_DP] = c.dp_s2;
        w[`B_DM] = c.dm_s2;
        w[`B_SLOW] = c.low_speed;
        w[`B_BRST] = c.bus_reset;
        w[`B_PEN] = c.port_en;
      end
      `IDX_EP_MODE: begin
        w[`B_TX_EN] = c.tx_en;
        w[`B_TX_DUAL] = c.tx_dual;
        w[`B_RX_EN] = c.rx_en;
        w[`B_RX_DUAL] = c.rx_dual;
      end
      `IDX_RX_ADDR: w[15:0] = c.rx_dma;
      `IDX_TX_ADDR: w[15:0] = c.tx_dma;
      `IDX_AUX_SETUP: begin
        w[`B_PRE] = c.pre_en;
        w[`B_SOF] = c.sof_en;
      end
      `IDX_TOKEN: w[7:0] = c.token;
      `IDX_RX_CTRL: begin
        w[`B_AUTO] = c.rx_auto;
        w[`B_TOG] = c.rx_tog;
        w[`B_RES] = t.no_hs;
      end
      `IDX_TX_LEN: w[16:0] = c.tx_len;
      `IDX_TX_CTRL: begin
        w[`B_AUTO] = c.tx_auto;
        w[`B_TOG] = c.tx_tog;
        w[`B_RES] = c.tx_res;
      end
      `IDX_STATUS: begin
        w[`B_DONE] = c.done_flag;
        w[`B_TOG_OK] = t.tog_ok;
        w[`B_HS_LSB +: 4] = t.hs_pid;
        w[`B_RXN_LSB +: 11] = t.rx_len;
      end
      `IDX_RX_MAX: w[10:0] = c.rx_max;
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // ================================================================
  // Next state
  always_comb begin
    n = s;
    n.start = 1'b0;
    n.sof_req = 1'b0;
    n.dp_s1 = dp_in;
    n.dp_s2 = s.dp_s1;
    n.dm_s1 = dm_in;
    n.dm_s2 = s.dm_s1;
    idx = address[8:2];
    m = {{8{byteenable[3]}}, {8{byteenable[2]}},
         {8{byteenable[1]}}, {8{byteenable[0]}}};
    rd = reg_word(idx, s, x);
    mrg = (rd & ~m) | (writedata & m);
    acc = (read || write) && !s.waitrequest;
    se0 = !s.dp_s2 && !s.dm_s2;
    if ((read || write) && s.waitrequest) begin
      n.waitrequest = 1'b0;
      n.readdata = read ? rd : 32'h0000_0000;
    end else begin
      n.waitrequest = 1'b1;
    end
    if (acc && write) begin
      case (idx)
        `IDX_PORT_CTRL: begin
          n.pd_dis = mrg[`B_PD_DIS];
          n.low_speed = mrg[`B_SLOW];
          n.bus_reset = mrg[`B_BRST];
          n.port_en = mrg[`B_PEN];
        end
        `IDX_EP_MODE: begin
          n.tx_en = mrg[`B_TX_EN];
          n.tx_dual = mrg[`B_TX_DUAL];
          n.rx_en = mrg[`B_RX_EN];
          n.rx_dual = mrg[`B_RX_DUAL];
        end
        `IDX_RX_ADDR: n.rx_dma = mrg[15:0];
        `IDX_TX_ADDR: n.tx_dma = mrg[15:0];
        `IDX_AUX_SETUP: begin
          n.pre_en = mrg[`B_PRE];
          n.sof_en = mrg[`B_SOF];
        end
        `IDX_TOKEN: begin
          n.token = mrg[7:0];
          n.start = byteenable[0] && s.port_en && !s.bus_reset && !busy;
        end
        `IDX_RX_CTRL: begin
          n.rx_auto = mrg[`B_AUTO];
          n.rx_tog = mrg[`B_TOG];
        end
        `IDX_TX_LEN: n.tx_len = mrg[16:0];
        `IDX_TX_CTRL: begin
          n.tx_auto = mrg[`B_AUTO];
          n.tx_tog = mrg[`B_TOG];
          n.tx_res = mrg[`B_RES];
        end
        `IDX_STATUS: begin
          if (writedata[`B_DONE] && byteenable[0]) begin
            n.done_flag = 1'b0;
          end
        end
        `IDX_RX_MAX: n.rx_max = mrg[10:0];
        default: n.token = s.token;
      endcase
    end
    // Hardware events win over software writes
    if (x.done) begin
      n.done_flag = 1'b1;
    end
    if (x.tx_flip && s.tx_auto) begin
      n.tx_tog = !s.tx_tog;
    end
    if (x.rx_flip && s.rx_auto) begin
      n.rx_tog = !s.rx_tog;
    end
    // Disconnect watch
    if (s.port_en && !s.bus_reset && se0) begin
      if (s.se0_cnt == DISC_LAST) begin
        n.port_en = 1'b0;
        n.se0_cnt = 9'h000;
      end else begin
        n.se0_cnt = s.se0_cnt + 9'h001;
      end
    end else begin
      n.se0_cnt = 9'h000;
    end
    // Frame timer
    if (s.sof_en && s.port_en && !s.bus_reset) begin
      if (s.frame_cnt == FRAME_LAST) begin
        n.frame_cnt = 17'h00000;
        n.sof_req = 1'b1;
      end else begin
        n.frame_cnt = s.frame_cnt + 17'h00001;
      end
    end else begin
      n.frame_cnt = 17'h00000;
    end
    n.pulldown_en = !n.pd_dis;
    n.line_oe = n.bus_reset;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s <= CTRL_RST;
    end else begin
      s <= n;
    end
  end

  // ================================================================
  // Transaction sequencer
  usbh_xact u_xact (
    .clk           (clk),
    .srst          (srst),
    .start         (s.start),
    .token         (s.token),
    .tx_en         (s.tx_en),
    .tx_dual       (s.tx_dual),
    .tx_tog        (s.tx_tog),
    .tx_res        (s.tx_res),
    .tx_dma        (s.tx_dma),
    .tx_len        (s.tx_len),
    .rx_en         (s.rx_en),
    .rx_dual       (s.rx_dual),
    .rx_tog        (s.rx_tog),
    .rx_dma        (s.rx_dma),
    .rx_max        (s.rx_max),
    .link_done     (link_done),
    .link_hs_pid   (link_hs_pid),
    .link_rx_ok    (link_rx_ok),
    .link_rx_data1 (link_rx_data1),
    .link_rx_len   (link_rx_len),
    .link_rx_no_hs (link_rx_no_hs),
    .busy          (busy),
    .q             (x)
  );

  // ================================================================
  // Outputs
  assign readdata = s.readdata;
  assign waitrequest = s.waitrequest;
  assign dp_out = 1'b0 & s.line_oe;
  assign dm_out = 1'b0 & s.line_oe;
  assign dp_oe = s.line_oe;
  assign dm_oe = s.line_oe;
  assign pulldown_en = s.pulldown_en;
  assign link_req = x.link_req;
  assign link_pid = x.link_pid;
  assign link_endp = x.link_endp;
  assign link_data1 = x.link_data1;
  assign link_expect_hs = x.link_expect_hs;
  assign link_addr = x.link_addr;
  assign link_len = x.link_len;
  assign link_slow_rate = s.low_speed;
  assign link_preamble = s.pre_en;
  assign sof_req = s.sof_req;

  // ================================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  logic port_wr;
  assign port_wr = write && !waitrequest && idx == `IDX_PORT_CTRL &&
                   byteenable[0];

  chk_pulldown_write: assert property (
    port_wr |=> pulldown_en == !$past(writedata[`B_PD_DIS]))
    else $error("pull-down does not follow control bit");
  chk_line_readback: assert property (
    (read && waitrequest && idx == `IDX_PORT_CTRL) |=>
      (readdata[`B_DP] == $past(s.dp_s2) &&
       readdata[`B_DM] == $past(s.dm_s2)))
    else $error("line level readback wrong");
  chk_speed_select: assert property (
    port_wr |=> link_slow_rate == $past(writedata[`B_SLOW]))
    else $error("speed select not applied");
  chk_reset_drive: assert property (
    port_wr |=> (dp_oe && dm_oe && !dp_out && !dm_out) ==
                $past(writedata[`B_BRST]))
    else $error("bus reset drive wrong");
  chk_disconnect_clear: assert property (
    (s.port_en && !s.bus_reset && se0 && s.se0_cnt == DISC_LAST &&
     !port_wr) |=> !s.port_en)
    else $error("port stays enabled after disconnect");
  chk_sof_gate: assert property (
    sof_req |-> $past(s.sof_en && s.port_en))
    else $error("frame start without enable");
  chk_tx_auto_flip: assert property (
    (x.tx_flip && s.tx_auto) |=> s.tx_tog != $past(s.tx_tog))
    else $error("transmit toggle did not flip");
  chk_rx_auto_flip: assert property (
    (x.rx_flip && s.rx_auto) |=> s.rx_tog != $past(s.rx_tog))
    else $error("receive toggle did not flip");
  chk_done_sets: assert property (
    x.done |=> s.done_flag)
    else $error("done flag not set");
  chk_start_to_req: assert property (
    (s.start && s.tx_en && (s.token[7:4] == PID_OUT)) |=> link_req)
    else $error("OUT not started");

  cov_in_done: cover property (x.done && x.link_pid == PID_IN);
  cov_out_ack: cover property (x.tx_flip && x.hs_pid == PID_ACK);
  cov_sof: cover property (sof_req);
  cov_disconnect: cover property ($fell(s.port_en) && !port_wr);
endmodule // usbh_port_ctrl

// *** tb/usbh_dev_model.sv ***
// Purpose: Far-side serial engine and device stand-in on the link ports
// Assumes: Link inputs matter only while link_done is high
// Notes:   Delay and toggle error are set by the bench
`timescale 1ns/1ps
module usbh_dev_model
  import usbh_pkg::*;
(
  input  logic        clk,
  input  logic        link_req,
  input  logic        link_data1,
  input  logic        link_expect_hs,
  input  logic [7:0]  delay,
  input  logic        bad_tog,
  output logic        link_done,
  output logic [3:0]  link_hs_pid,
  output logic        link_rx_ok,
  output logic        link_rx_data1,
  output logic [10:0] link_rx_len,
  output logic        link_rx_no_hs
);
  logic [7:0] cnt;

  assign link_rx_ok    = 1'b1;
  assign link_rx_no_hs = bad_tog;

  initial begin
    cnt = 8'h00;
    link_done = 1'b0;
    link_hs_pid = 4'h5;
    link_rx_data1 = 1'b0;
    link_rx_len = 11'h2a5;
  end

  // ================================================================
  // Answer each request after the set delay
  always @(posedge clk) begin
    link_done <= 1'b0;
    link_hs_pid <= ~link_hs_pid;
    link_rx_data1 <= ~link_rx_data1;
    link_rx_len <= ~link_rx_len;
    if (link_req && !link_done) begin
      cnt <= cnt + 8'h01;
      if (cnt == delay) begin
        cnt <= 8'h00;
        link_done <= 1'b1;
        link_hs_pid <= link_expect_hs ? PID_ACK : 4'h0;
        link_rx_data1 <= link_data1 ^ bad_tog;
        link_rx_len <= 11'h007;
      end
    end
  end
endmodule // usbh_dev_model

// *** tb/usbh_host_port_endpoint_control_tb_top.sv ***
// Purpose: Register-level tests of the host port control block
// Assumes: Byte address is index times four, frame shortened to 64
// Notes:   Far side answered by the device model
`timescale 1ns/1ps
`include "usbh_cfg.svh"
module usbh_host_port_endpoint_control_tb_top;
  import usbh_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [8:0]  address = 9'h000;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        dp_in = 1'b1;
  logic        dm_in = 1'b0;
  logic        dp_out, dm_out, dp_oe, dm_oe, pulldown_en;
  logic        link_req, link_data1, link_expect_hs;
  logic [3:0]  link_pid, link_endp, link_hs_pid;
  logic [14:0] link_addr;
  logic [16:0] link_len;
  logic        link_slow_rate, link_preamble, sof_req;
  logic        link_done, link_rx_ok, link_rx_data1, link_rx_no_hs;
  logic [10:0] link_rx_len;
  logic [7:0]  delay = 8'h03;
  logic        bad_tog = 1'b0;
  int          n_fail = 0;
  int          num_checks = 0;
  logic [6:0]  ti [9] = '{`IDX_EP_MODE, `IDX_RX_ADDR, `IDX_TX_ADDR,
    `IDX_AUX_SETUP, `IDX_RX_CTRL, `IDX_TX_LEN, `IDX_TX_CTRL,
    `IDX_RX_MAX, 7'h02};
  logic [31:0] te [9] = '{32'h59, 32'hffff, 32'hffff, 32'h0404,
    32'h0c, 32'h1ffff, 32'h0d, 32'h7ff, 32'h0};

  initial begin
    forever #4 clk = ~clk;
  end

  usbh_port_ctrl #(.FRAME_CYCLES(64)) DUT (
    .clk(clk), .srst(srst), .address(address), .read(read),
    .write(write), .byteenable(4'hf), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .dp_in(dp_in),
    .dm_in(dm_in), .dp_out(dp_out), .dm_out(dm_out), .dp_oe(dp_oe),
    .dm_oe(dm_oe), .pulldown_en(pulldown_en), .link_req(link_req),
    .link_pid(link_pid), .link_endp(link_endp),
    .link_data1(link_data1), .link_expect_hs(link_expect_hs),
    .link_addr(link_addr), .link_len(link_len),
    .link_slow_rate(link_slow_rate), .link_preamble(link_preamble),
    .sof_req(sof_req), .link_done(link_done),
    .link_hs_pid(link_hs_pid), .link_rx_ok(link_rx_ok),
    .link_rx_data1(link_rx_data1), .link_rx_len(link_rx_len),
    .link_rx_no_hs(link_rx_no_hs));

  usbh_dev_model peer (
    .clk(clk), .link_req(link_req), .link_data1(link_data1),
    .link_expect_hs(link_expect_hs), .delay(delay), .bad_tog(bad_tog),
    .link_done(link_done), .link_hs_pid(link_hs_pid),
    .link_rx_ok(link_rx_ok), .link_rx_data1(link_rx_data1),
    .link_rx_len(link_rx_len), .link_rx_no_hs(link_rx_no_hs));

  // ================================================================
  // Tasks
  task automatic wrap_up();
    if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic bus(input logic rd, input logic [6:0] i,
                     input logic [31:0] d, output logic [31:0] q);
    int k;
    address <= {i, 2'b00};
    writedata <= d;
    read <= rd;
    write <= ~rd;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    q = readdata;
    if (k == 50) begin
      n_fail++;
      wrap_up();
    end
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic bw(input logic [6:0] i, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b0, i, d, q);
  endtask

  task automatic rc(input logic [6:0] i, input logic [31:0] e,
                    input logic [31:0] m);
    logic [31:0] q;
    bus(1'b1, i, 32'h0, q);
    chk(q & m, e);
  endtask

  task automatic wreq(input logic v);
    int k;
    for (k = 0; k < 200; k++) begin
      if (link_req === v) break;
      @(posedge clk);
    end
    if (k == 200) begin
      n_fail++;
      wrap_up();
    end
  endtask

  task automatic sofs(input int e);
    int n;
    n = 0;
    repeat (256) begin
      @(posedge clk);
      n += int'(sof_req === 1'b1);
    end
    chk(32'(n), 32'(e));
  endtask

  task automatic xact(input logic [7:0] tok, input logic [14:0] a,
                      input logic [16:0] len, input logic [1:0] hs);
    bw(`IDX_TOKEN, {24'h0, tok});
    wreq(1'b1);
    chk({24'h0, link_pid, link_endp}, {24'h0, tok});
    chk(32'(link_addr), 32'(a));
    chk(32'(link_len), 32'(len));
    chk({30'h0, link_data1, link_expect_hs}, {30'h0, hs});
    wreq(1'b0);
    tick(2);
  endtask

  // ================================================================
  // Main sequence
  initial begin
    tick(2);
    srst <= 1'b0;
    tick(4);
    chk({31'h0, pulldown_en}, 32'h0);
    rc(`IDX_PORT_CTRL, 32'ha0, 32'hff);
    bw(`IDX_PORT_CTRL, 32'h07);
    tick(3);
    chk({26'h0, pulldown_en, link_slow_rate, dp_oe, dm_oe, dp_out, dm_out},
        32'h3c);
    bw(`IDX_PORT_CTRL, 32'h01);
    tick(3);
    chk({29'h0, link_slow_rate, dp_oe, dm_oe}, 32'h0);
    rc(`IDX_PORT_CTRL, 32'h21, 32'hff);
    for (int i = 0; i < 9; i++) begin
      bw(ti[i], 32'hffff_ffff);
      rc(ti[i], te[i], 32'hffff_ffff);
    end
    chk({31'h0, link_preamble}, 32'h1);
    sofs(4);
    bw(`IDX_AUX_SETUP, 32'h0);
    tick(3);
    chk({31'h0, link_preamble}, 32'h0);
    sofs(0);
    bw(`IDX_TX_ADDR, 32'h8100);
    bw(`IDX_TX_LEN, 32'h10005);
    bw(`IDX_TX_CTRL, 32'h0c);
    xact(8'h13, 15'h0140, 17'h10005, 2'b11);
    rc(`IDX_STATUS, 32'h21, 32'hf1);
    rc(`IDX_TX_CTRL, 32'h08, 32'hff);
    bw(`IDX_STATUS, 32'h1);
    rc(`IDX_STATUS, 32'h0, 32'h1);
    delay <= 8'd40;
    bw(`IDX_TX_CTRL, 32'h01);
    xact(8'hd0, 15'h0100, 17'h10005, 2'b00);
    rc(`IDX_TX_CTRL, 32'h01, 32'hff);
    rc(`IDX_STATUS, 32'h1, 32'h1);
    bw(`IDX_STATUS, 32'h1);
    delay <= 8'h02;
    bw(`IDX_RX_ADDR, 32'h0200);
    bw(`IDX_RX_MAX, 32'h40);
    bw(`IDX_RX_CTRL, 32'h08);
    xact(8'h91, 15'h0200, 17'h40, 2'b01);
    rc(`IDX_STATUS, 32'h0007_0003, 32'h07ff_0003);
    rc(`IDX_RX_CTRL, 32'h0c, 32'hff);
    bw(`IDX_STATUS, 32'h1);
    bad_tog <= 1'b1;
    xact(8'h91, 15'h0240, 17'h40, 2'b11);
    rc(`IDX_STATUS, 32'h1, 32'h3);
    rc(`IDX_RX_CTRL, 32'h0d, 32'hff);
    bw(`IDX_STATUS, 32'h1);
    bw(`IDX_EP_MODE, 32'h0);
    bw(`IDX_TOKEN, 32'h91);
    tick(20);
    chk({31'h0, link_req}, 32'h0);
    bw(`IDX_TOKEN, 32'h11);
    tick(20);
    chk({31'h0, link_req}, 32'h0);
    rc(`IDX_STATUS, 32'h0, 32'h1);
    dp_in <= 1'b0;
    tick(330);
    rc(`IDX_PORT_CTRL, 32'h00, 32'h31);
    wrap_up();
  end
endmodule // usbh_host_port_endpoint_control_tb_top
